// ### inc/dmc_pkg.sv
// Purpose: Shared constants for the DC motor channel control/status bank
// Assumes: Register byte address is four times the register index
// Notes:   Read and write maps are separate images sharing index space
package dmc_pkg;
   // Channel count in the two-channel configuration
   localparam int NCH = 2;
   // Register indices, feedback (read) image
   localparam logic [5:0] IDX_FLT0 = 6'h00;  // Fault flags, channel 0
   localparam logic [5:0] IDX_STS0 = 6'h01;  // Status byte, channel 0
   localparam logic [5:0] IDX_FLT1 = 6'h08;  // Fault flags, channel 1
   localparam logic [5:0] IDX_STS1 = 6'h09;  // Status byte, channel 1
   // Register indices, control (write) image
   localparam logic [5:0] IDX_CTL0 = 6'h09;  // Output control, channel 0
   localparam logic [5:0] IDX_CLR0 = 6'h0A;  // Error clear, channel 0
   localparam logic [5:0] IDX_CTL1 = 6'h15;  // Output control, channel 1
   localparam logic [5:0] IDX_CLR1 = 6'h16;  // Error clear, channel 1
   // Interrupt registers, both read and write
   localparam logic [5:0] IDX_IRQ_STS  = 6'h20;  // Sticky events, W1C
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;  // Enable mask
   // Address bits that select the register index
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 7;
   // Control and error clear byte fields
   localparam int B_RUN_EN   = 0;  // Software run enable
   localparam int B_OVR_SEL  = 1;  // Output override select
   localparam int B_MAN_A    = 3;  // Manual level, output A
   localparam int B_MAN_B    = 4;  // Manual level, output B
   localparam int B_FLT_CLR  = 0;  // Fault clear request
   // Fault byte fields
   localparam int B_UNDERV   = 0;  // Supply under-voltage
   localparam int B_AUX_SHT  = 1;  // 24 V output short/overload
   localparam int B_LD_FLT   = 2;  // Parameter load fault
   localparam int B_OUTA_SHT = 4;  // Output A short
   localparam int B_OUTB_SHT = 5;  // Output B short
   // Status byte field
   localparam int B_RUN_ECHO = 5;  // Run enable echo
   // Interrupt event layout: four events per channel
   localparam int EV_PER_CH  = 4;
   localparam int EV_AUX     = 0;
   localparam int EV_LD      = 1;
   localparam int EV_OUTA    = 2;
   localparam int EV_OUTB    = 3;
   localparam int NEV        = NCH * EV_PER_CH;
   // Reset values
   localparam logic [7:0]     BYTE_RST = 8'h00;
   localparam logic [NEV-1:0] EV_RST   = '0;
   // Input pin function encodings
   localparam logic [1:0] FN_PLAIN = 2'h0;  // Plain input
   localparam logic [1:0] FN_STOP  = 2'h1;  // External stop
   localparam logic [1:0] FN_HWEN  = 2'h2;  // Hardware enable
endpackage

// ### verilog/dmc_channel_bank.sv
// Purpose: Control/feedback bank of a pulse module in DC motor mode
// Assumes: Classic Wishbone slave, 32-bit data, byte lane 0 used
// Notes:   Functional notes below; channel 1 exists in two-channel mode
//          Fault clear is a level: software writes one, then zero
//          Unused control bits are don't care; zero is expected
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module dmc_channel_bank #(
   parameter int NCH_P = dmc_pkg::NCH  // Channel count
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             ce,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [31:0]      wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Configuration
   input  wire logic             two_channel_cfg,
   input  wire logic [1:0]       input_pin_function,
   // Per-channel plant inputs
   input  wire logic [NCH_P-1:0] hw_enable_in,
   input  wire logic [NCH_P-1:0] supply_present,
   input  wire logic [NCH_P-1:0] supply_low,
   input  wire logic [NCH_P-1:0] aux_short_det,
   input  wire logic [NCH_P-1:0] out_a_short_det,
   input  wire logic [NCH_P-1:0] out_b_short_det,
   input  wire logic [NCH_P-1:0] pwm_phase,
   input  wire logic [NCH_P-1:0] dir_reverse,
   input  wire logic [NCH_P-1:0] param_load_req,
   input  wire logic [NCH_P-1:0] param_load_bad,
   input  wire logic [NCH_P-1:0] single_update_mode,
   // Per-channel results, then the shared interrupt
   output logic      [NCH_P-1:0] param_load_ack,
   output logic      [NCH_P-1:0] seq_running,
   output logic      [NCH_P-1:0] drive_output_a,
   output logic      [NCH_P-1:0] drive_output_b,
   output logic                  irq
);

   // All registered state of the block except the reset synchroniser
   // One record so reset, freeze and update treat every flop alike
   typedef struct packed {
      logic [NCH_P-1:0][7:0]  ctl;      // Output control bytes
      logic [NCH_P-1:0][7:0]  clr;      // Error clear bytes
      logic [NCH_P-1:0][7:0]  flt;      // Fault flag bytes
      logic [NCH_P-1:0]       run_prev; // Run enable, last cycle
      logic [NCH_P-1:0]       running;  // Output sequence running
      logic [NCH_P-1:0]       ld_ack;   // Load accepted pulse
      logic [NCH_P-1:0]       out_a;    // Output A level
      logic [NCH_P-1:0]       out_b;    // Output B level
      logic [dmc_pkg::NEV-1:0] ev;      // Sticky interrupt events
      logic [dmc_pkg::NEV-1:0] mask;    // Interrupt mask
      logic                   irq;      // Interrupt output
      logic                   ack;      // Bus acknowledge
      logic [31:0]            rdat;     // Bus read data
   } dmc_state_t;

   dmc_state_t st_r;   // Current state
   dmc_state_t st_nxt; // Next state
   logic       rs1_r;  // Reset release, first stage
   logic       rs2_r;  // Reset release, synchronised copy

   // Reset release synchroniser
   // Assertion of nrst reaches the state at once; release is retimed
   // through two flops so every state flop leaves reset on one edge.
   // Nothing but the second stage reads the first stage.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end

   // Next-state logic
   // Register map, by index (byte address divided by four):
   //   read  0x00/0x08 fault flags, 0x01/0x09 status, channel 0/1
   //   write 0x09/0x15 output control, 0x0A/0x16 error clear
   //   both  0x20 sticky events (write one to clear), 0x21 mask
   // Read and write images overlap at 0x09 on purpose: a read there
   // returns channel 1 status, a write lands in channel 0 control.
   // Every request is answered, mapped or not, so a stray access
   // never stalls the controller.
   always_comb begin
      logic [5:0]  idx;     // Register index of request
      logic        req;     // New bus request this cycle
      logic        wr;      // Write strobe, lane 0
      logic [7:0]  wb;      // Written byte
      logic [NCH_P-1:0] ch_on; // Channel present
      logic [dmc_pkg::NEV-1:0] ev_set; // Events this cycle
      logic        run_en;  // Run enable bit
      logic        start;   // Start condition
      logic [7:0]  sts;     // Status byte
      st_nxt = st_r;
      idx    = wb_adr_i[dmc_pkg::IDX_MSB:dmc_pkg::IDX_LSB];
      req    = wb_cyc_i & wb_stb_i & ~st_r.ack;
      wr     = req & wb_we_i & wb_sel_i[0];
      wb     = wb_dat_i[7:0];
      ev_set = '0;
      run_en = 1'b0;
      start  = 1'b0;
      sts    = dmc_pkg::BYTE_RST;
      // Channel 1 present only in two-channel mode
      ch_on    = '1;
      ch_on[1] = two_channel_cfg;
      // Load acknowledge is a one-cycle pulse
      st_nxt.ld_ack = '0;

      // Control register writes
      // Writes need lane 0 selected; other lanes carry nothing
      if (wr && idx == dmc_pkg::IDX_CTL0) begin
         st_nxt.ctl[0] = wb;
      end
      if (wr && idx == dmc_pkg::IDX_CLR0) begin
         st_nxt.clr[0] = wb;
      end
      if (wr && ch_on[1] && idx == dmc_pkg::IDX_CTL1) begin
         st_nxt.ctl[1] = wb;
      end
      if (wr && ch_on[1] && idx == dmc_pkg::IDX_CLR1) begin
         st_nxt.clr[1] = wb;
      end

      // Per-channel behaviour
      // Order inside a channel matters: the clear level is applied
      // before the detectors, so a fault seen in the clearing cycle
      // survives; load refusal reads the registered flag, so a load
      // in the clearing cycle is still refused.
      for (int c = 0; c < NCH_P; c++) begin
         if (!ch_on[c]) begin
            // Absent channel held idle and cleared
            // Writes to it are dropped above and it reads as zero
            st_nxt.ctl[c]    = dmc_pkg::BYTE_RST;
            st_nxt.clr[c]    = dmc_pkg::BYTE_RST;
            st_nxt.flt[c]    = dmc_pkg::BYTE_RST;
            st_nxt.run_prev[c] = 1'b0;
            st_nxt.running[c]  = 1'b0;
            st_nxt.out_a[c]    = 1'b0;
            st_nxt.out_b[c]    = 1'b0;
         end else begin
            run_en = st_r.ctl[c][dmc_pkg::B_RUN_EN];
            st_nxt.run_prev[c] = run_en;
            // Start per input pin function
            if (input_pin_function == dmc_pkg::FN_PLAIN ||
                input_pin_function == dmc_pkg::FN_STOP) begin
               start = run_en & ~st_r.run_prev[c];
            end else if (input_pin_function == dmc_pkg::FN_HWEN) begin
               // Level start while the enable pin is high
               start = run_en & hw_enable_in[c];
            end else begin
               // Unused function code: never starts
               start = 1'b0;
            end
            if (!run_en) begin
               st_nxt.running[c] = 1'b0;
            end else if (start) begin
               st_nxt.running[c] = 1'b1;
            end
            // Module drives outputs; override and manual bits unused
            // Direction picks which output carries the PWM level
            st_nxt.out_a[c] = st_nxt.running[c] & pwm_phase[c]
                              & ~dir_reverse[c];
            st_nxt.out_b[c] = st_nxt.running[c] & pwm_phase[c]
                              & dir_reverse[c];

            // Live under-voltage, only with supply present
            // Not latched: follows the supply inputs one cycle late
            st_nxt.flt[c][dmc_pkg::B_UNDERV] =
               supply_present[c] & supply_low[c];

            // Clear level first, so a new event wins
            if (st_r.clr[c][dmc_pkg::B_FLT_CLR]) begin
               st_nxt.flt[c][dmc_pkg::B_AUX_SHT]  = 1'b0;
               st_nxt.flt[c][dmc_pkg::B_LD_FLT]   = 1'b0;
               st_nxt.flt[c][dmc_pkg::B_OUTA_SHT] = 1'b0;
               st_nxt.flt[c][dmc_pkg::B_OUTB_SHT] = 1'b0;
            end
            if (aux_short_det[c]) begin
               st_nxt.flt[c][dmc_pkg::B_AUX_SHT] = 1'b1;
               ev_set[c*dmc_pkg::EV_PER_CH + dmc_pkg::EV_AUX] = 1'b1;
            end
            if (out_a_short_det[c]) begin
               st_nxt.flt[c][dmc_pkg::B_OUTA_SHT] = 1'b1;
               ev_set[c*dmc_pkg::EV_PER_CH + dmc_pkg::EV_OUTA] = 1'b1;
            end
            if (out_b_short_det[c]) begin
               st_nxt.flt[c][dmc_pkg::B_OUTB_SHT] = 1'b1;
               ev_set[c*dmc_pkg::EV_PER_CH + dmc_pkg::EV_OUTB] = 1'b1;
            end
            // Parameter load handling
            if (param_load_req[c]) begin
               if (st_r.flt[c][dmc_pkg::B_LD_FLT]) begin
                  // Refused while a load fault stands
                  st_nxt.ld_ack[c] = 1'b0;
               end else if (param_load_bad[c]) begin
                  // Bad value: flagged in single-update mode only
                  if (single_update_mode[c]) begin
                     st_nxt.flt[c][dmc_pkg::B_LD_FLT] = 1'b1;
                     ev_set[c*dmc_pkg::EV_PER_CH + dmc_pkg::EV_LD] = 1'b1;
                  end
               end else begin
                  // Good load accepted
                  st_nxt.ld_ack[c] = 1'b1;
               end
            end
         end
      end

      // Sticky events: set wins over write-one-clear
      // Events are one bit per latched fault source and channel; the flag
      // clear level above does not touch them, software clears
      // them separately here.
      if (wr && idx == dmc_pkg::IDX_IRQ_STS) begin
         st_nxt.ev = st_r.ev & ~wb_dat_i[dmc_pkg::NEV-1:0];
      end
      st_nxt.ev = st_nxt.ev | ev_set;
      if (wr && idx == dmc_pkg::IDX_IRQ_MASK) begin
         st_nxt.mask = wb_dat_i[dmc_pkg::NEV-1:0];
      end
      // Level interrupt follows the new events and mask
      st_nxt.irq = |(st_nxt.ev & st_nxt.mask);

      // Bus answer: one ack per request, read data registered
      // A request is not taken again while its ack stands, so a
      // master that holds stb one cycle too long is not answered twice.
      // Read data is zero whenever no read is answered.
      st_nxt.ack  = req;
      st_nxt.rdat = '0;
      if (req && !wb_we_i) begin
         case (idx)
            dmc_pkg::IDX_FLT0: begin
               st_nxt.rdat[7:0] = st_r.flt[0];
            end
            dmc_pkg::IDX_STS0: begin
               sts[dmc_pkg::B_RUN_ECHO] = st_r.ctl[0][dmc_pkg::B_RUN_EN];
               st_nxt.rdat[7:0] = sts;
            end
            dmc_pkg::IDX_FLT1: begin
               st_nxt.rdat[7:0] = st_r.flt[1];
            end
            dmc_pkg::IDX_STS1: begin
               sts[dmc_pkg::B_RUN_ECHO] = st_r.ctl[1][dmc_pkg::B_RUN_EN];
               st_nxt.rdat[7:0] = sts;
            end
            dmc_pkg::IDX_IRQ_STS: begin
               st_nxt.rdat[dmc_pkg::NEV-1:0] = st_r.ev;
            end
            dmc_pkg::IDX_IRQ_MASK: begin
               st_nxt.rdat[dmc_pkg::NEV-1:0] = st_r.mask;
            end
            default: begin
               st_nxt.rdat = '0; // Unmapped reads as zero
            end
         endcase
      end
   end

   // State register, frozen while ce is low
   // The freeze also holds ack and any pulse output, so a bus cycle
   // simply stretches while ce is low; detector pulses in that time
   // are lost.
   always_ff @(posedge core_clk or negedge rs2_r) begin
      if (!rs2_r) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flip-flops
   // No output passes through logic after the register
   assign wb_dat_o       = st_r.rdat;
   assign wb_ack_o       = st_r.ack;
   assign param_load_ack = st_r.ld_ack;
   assign seq_running    = st_r.running;
   assign drive_output_a = st_r.out_a;
   assign drive_output_b = st_r.out_b;
   assign irq            = st_r.irq;

endmodule

// ### sim/dmc_bank_checker.sv
// Purpose: Port-level checks of the channel bank
// Assumes: Channel 0 plant pins; ce lowered only while the bus idles
// Notes:   Attached to every bank instance by the bind below
`timescale 1ns/1ps
module dmc_bank_checker #(
   parameter int NCH_P = 2  // Channel count
) (
   input wire logic             core_clk,
   input wire logic             nrst,
   input wire logic             ce,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_ack_o,
   input wire logic             irq,
   input wire logic [NCH_P-1:0] hw_enable_in,
   input wire logic [NCH_P-1:0] aux_short_det,
   input wire logic [NCH_P-1:0] out_a_short_det,
   input wire logic [NCH_P-1:0] out_b_short_det,
   input wire logic [NCH_P-1:0] pwm_phase,
   input wire logic [NCH_P-1:0] dir_reverse,
   input wire logic [NCH_P-1:0] param_load_req,
   input wire logic [NCH_P-1:0] param_load_bad,
   input wire logic [NCH_P-1:0] param_load_ack,
   input wire logic [NCH_P-1:0] seq_running,
   input wire logic [NCH_P-1:0] drive_output_a,
   input wire logic [NCH_P-1:0] drive_output_b
);
   // One clock domain, one reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_ack_one_cycle: assert property (ce && wb_ack_o ##1 ce |-> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_after_req: assert property
      (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_out_a_cause: assert property (drive_output_a[0] |->
      $past(pwm_phase[0] && !dir_reverse[0])) else $error("bad out a");
   a_out_b_cause: assert property (drive_output_b[0] |->
      $past(pwm_phase[0] && dir_reverse[0])) else $error("bad out b");
   a_outs_idle_stop: assert property
      (drive_output_a[0] || drive_output_b[0] |->
       seq_running[0] || $past(seq_running[0]))
      else $error("output driven while stopped");
   a_run_start_cause: assert property ($rose(seq_running[0]) |->
      $past(wb_cyc_i, 2) || $past(hw_enable_in[0]))
      else $error("sequence started without cause");
   a_load_ack_ok: assert property (param_load_ack[0] |->
      $past(param_load_req[0] && !param_load_bad[0]))
      else $error("load ack without good request");
   a_load_bad_nack: assert property
      (param_load_req[0] && param_load_bad[0] |=> !param_load_ack[0])
      else $error("bad load acknowledged");
   a_irq_rise_cause: assert property ($rose(irq) |->
      $past(wb_cyc_i) || $past(wb_cyc_i, 2) || $past(|{aux_short_det,
      out_a_short_det, out_b_short_det, param_load_req}))
      else $error("irq rose without cause");
   // Main scenarios reached
   c_run: cover property ($rose(seq_running[0]));
   c_load: cover property (param_load_ack[0]);
   c_irq: cover property ($rose(irq));
endmodule
bind dmc_channel_bank dmc_bank_checker #(.NCH_P(NCH_P)) u_chk (
   .core_clk, .nrst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq,
   .hw_enable_in, .aux_short_det, .out_a_short_det, .out_b_short_det,
   .pwm_phase, .dir_reverse, .param_load_req, .param_load_bad,
   .param_load_ack, .seq_running, .drive_output_a, .drive_output_b);

// ### sim/dmc_host_model.sv
// Purpose: Controller writing and reading the process image
// Assumes: Classic Wishbone, byte lane 0
// Notes:   Waits on ack without limit; the bench timeout cuts a hang
`timescale 1ns/1ps
module dmc_host_model (
   input  wire logic        core_clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [31:0]      adr,
   output logic [31:0]      wdat,
   output logic [3:0]       sel
);
   // Bus idle at time zero
   initial begin
      {cyc, stb, we, adr, wdat, sel} = '0;
   end
   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
      adr  <= {24'h0, a};
      wdat <= {24'h0, d};  // Unused bits zero
      do @(posedge core_clk); while (ack !== 1'b1);
      q = rdat[7:0];
      {cyc, stb, we} <= 3'h0;
   endtask
   // Pulse the fault clear bit high then back low
   task automatic clear_faults(input logic [7:0] a);
      logic [7:0] q;
      xfer(1'b1, a, 8'h01, q);
      xfer(1'b1, a, 8'h00, q);
   endtask
endmodule

// ### sim/dmc_channel_bank_tb.sv
// Purpose: Self-checking bench of the channel bank
// Assumes: ce high except in the freeze case; hw enable low until the hardware enable case
// Notes:   Fault table first, then run, load and channel 1 cases
`timescale 1ns/1ps
module dmc_channel_bank_tb;
   logic        core_clk = 1'b0, nrst = 1'b0, two_ch = 1'b1, ce = 1'b1;
   logic [1:0]  fn = 2'h0, hw = 2'h0, sp = 2'h0, sl = 2'h0, aux = 2'h0;
   logic [1:0]  sa = 2'h0, sb = 2'h0, pwm = 2'h0, dir = 2'h0;
   logic [1:0]  ldq = 2'h0, ldb = 2'h0, one = 2'h0;
   logic [1:0]  ldk, run, dqa, dqb;
   logic        cyc, stb, we, ack, irq;
   logic [31:0] adr, wd, rd;
   logic [3:0]  sel;
   int          error_cnt = 0, samples_checked = 0, cycles = 0;
   // Rows: {present, low, aux, out a, out b}, fault byte, irq events
   logic [20:0] rows [5] = '{{5'h04, 8'h02, 8'h01}, {5'h02, 8'h10,
      8'h04}, {5'h01, 8'h20, 8'h08}, {5'h18, 8'h01, 8'h00},
      {5'h08, 8'h00, 8'h00}};
   dmc_channel_bank u_dmc_channel_bank (.core_clk, .nrst, .ce,
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack),
      .two_channel_cfg(two_ch), .input_pin_function(fn),
      .hw_enable_in(hw), .supply_present(sp), .supply_low(sl),
      .aux_short_det(aux), .out_a_short_det(sa), .out_b_short_det(sb),
      .pwm_phase(pwm), .dir_reverse(dir), .param_load_req(ldq),
      .param_load_bad(ldb), .single_update_mode(one),
      .param_load_ack(ldk), .seq_running(run), .drive_output_a(dqa),
      .drive_output_b(dqb), .irq);
   dmc_host_model u_dmc_host_model (.core_clk, .ack, .rdat(rd), .cyc,
      .stb, .we, .adr, .wdat(wd), .sel);
   // Clock, 10 ns period
   initial forever #5 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_dmc_host_model.xfer(1'b0, a, 8'h00, q);
      chk(e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_dmc_host_model.xfer(1'b1, a, d, q);
   endtask
   // Load request pulse, ack looked at while it stands
   task automatic load(input logic bad, input logic e);
      @(posedge core_clk);
      {ldb, ldq} <= {1'b0, bad, 2'h1};
      @(posedge core_clk);
      ldq <= 2'h0;
      @(posedge core_clk);
      chk({7'h0, e}, {7'h0, ldk[0]});
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h04, 8'h00);
      wr(8'h84, 8'hFF);
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         {sp[0], sl[0], aux[0], sa[0], sb[0]} <= rows[i][20:16];
         rd_chk(8'h00, rows[i][15:8]);
         @(posedge core_clk);
         {sp[0], sl[0], aux[0], sa[0], sb[0]} <= 5'h0;
         rd_chk(8'h00, rows[i][15:8] & 8'hFE);
         chk({7'h0, |rows[i][7:0]}, {7'h0, irq});
         rd_chk(8'h80, rows[i][7:0]);
         wr(8'h80, rows[i][7:0]);
         u_dmc_host_model.clear_faults(8'h28);
         rd_chk(8'h00, 8'h00);
         chk(8'h00, {7'h0, irq});
      end
      $display("fault table done");
      pwm <= 2'h1;
      for (int k = 0; k < 4; k++) begin
         fn <= k[1:0];
         wr(8'h24, 8'h01);
         repeat (3) @(posedge core_clk);
         chk({7'h0, k < 2}, {7'h0, run[0]});
         chk({7'h0, k < 2}, {6'h0, dqb[0], dqa[0]});
         rd_chk(8'h04, 8'h20);
         dir <= 2'h1;
         wr(8'h24, 8'h1B);
         repeat (3) @(posedge core_clk);
         chk({6'h0, k < 2, 1'b0}, {6'h0, dqb[0], dqa[0]});
         dir <= 2'h0;
         wr(8'h24, 8'h00);
         repeat (3) @(posedge core_clk);
         chk(8'h00, {6'h0, run[0], dqa[0]});
      end
      $display("run done");
      one <= 2'h1;
      load(1'b1, 1'b0);
      rd_chk(8'h00, 8'h04);
      load(1'b0, 1'b0);
      u_dmc_host_model.clear_faults(8'h28);
      load(1'b0, 1'b1);
      one <= 2'h0;
      load(1'b1, 1'b0);
      rd_chk(8'h00, 8'h00);
      $display("load done");
      wr(8'h84, 8'h00);
      {two_ch, aux} <= 3'h2;
      rd_chk(8'h20, 8'h00);
      two_ch <= 1'b1;
      rd_chk(8'h20, 8'h02);
      aux <= 2'h0;
      u_dmc_host_model.clear_faults(8'h58);
      rd_chk(8'h20, 8'h00);
      rd_chk(8'h40, 8'h00);
      wr(8'h80, 8'hFF);
      sa <= 2'h1;
      @(posedge core_clk);
      sa <= 2'h0;
      rd_chk(8'h80, 8'h04);
      chk(8'h00, {7'h0, irq});
      wr(8'h84, 8'h04);
      repeat (2) @(posedge core_clk);
      chk(8'h01, {7'h0, irq});
      wr(8'h80, 8'h04);
      repeat (2) @(posedge core_clk);
      chk(8'h00, {7'h0, irq});
      $display("irq done");
      // Hardware enable start, then reset in mid-run
      fn <= 2'h2;
      hw <= 2'h1;
      wr(8'h24, 8'h01);
      repeat (3) @(posedge core_clk);
      chk(8'h03, {6'h0, run[0], dqa[0]});
      nrst <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk(8'h00, {4'h0, run[0], dqa[0], ack, irq});
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd_chk(8'h04, 8'h00);
      // Frozen state misses a detector pulse
      {ce, sb} <= 3'h1;
      @(posedge core_clk);
      {ce, sb} <= 3'h4;
      rd_chk(8'h00, 8'h00);
      $display("reset done");
      end_of_test();
   end
endmodule
